// >>> rtl/video_capture_pkg.sv
// Purpose: Shared constants and types for the video input capture block.
// Assumes: Load clock is sampled by the 200 MHz core clock.
// Notes: Pipeline depths and sync offsets are plain defaults.
package video_capture_pkg;
  localparam int PIX_W = 64;
  localparam int LEGACY_W = 8;
  localparam int MASK_W = 8;
  localparam int NIB_W = 4;
  localparam int HALF_W = 32;
  localparam int PIPE_DEPTH = 4;
  localparam int HPOS_W = 3;
  localparam logic [PIX_W-1:0] PIX_RESET = 64'h0;

  typedef struct packed {
    logic [PIX_W-1:0] pixel;
    logic [LEGACY_W-1:0] legacy;
    logic active;
    logic show_border;
    logic field_odd;
    logic line_sync;
  } capture_word_t;

  localparam int WORD_W = $bits(capture_word_t);
endpackage

// >>> rtl/video_input_capture.sv
// Purpose: Capture pixel, legacy byte and video control inputs on load clock.
// Assumes: All pins are asynchronous to clock; load_clock is sampled.
// Notes: A two-entry buffer holds captured words until the sink takes them.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: All video inputs are captured on load clock edges.
// R2: Pixel width is 64 or 32 bits by bus_width_select, rising edge.
// R3: In 32-bit mode pixel bits 63:32 are forced to zero.
// R4: The legacy byte is sampled each rising load clock edge.
// R5: Blanking low means blanking time, high means active picture.
// R6: Frame-edge input acts as border or odd/even by configuration.
// R7: In border use, low border during picture selects border colour.
// R8: Controller holds border low during blanking.
// R9: Board ties border to blanking where no border is wanted.
// R10: In interlace use, the field input selects the cursor row.
// R11: Controller changes the field input only in vertical blanking.
// R12: Sync input serves as horizontal or composite sync.
// R13: Horizontal sync is output delayed to match pixel data.
// R14: A control bit inverts incoming sync polarity.
// R15: PLL clock output is driven or released under control.
// R16: Horizontal sync delay is adjustable by a position setting.
// R17: With masking enabled, set mask bits zero their pixel nibbles.
// R18: All samples from one edge pass equal-depth pipelines.
module video_input_capture
  import video_capture_pkg::*;
#(
  parameter int DEPTH = PIPE_DEPTH
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic load_clock,
  input wire logic [video_capture_pkg::PIX_W-1:0] vram_word_bus,
  input wire logic [video_capture_pkg::LEGACY_W-1:0] legacy_byte,
  input wire logic blank_n,
  input wire logic frame_edge_in,
  input wire logic line_sync_in,
  input wire logic bus_width_select,
  input wire logic interlace_mode,
  input wire logic composite_sync_mode,
  input wire logic sync_invert,
  input wire logic [video_capture_pkg::HPOS_W-1:0] hsync_position,
  input wire logic input_mask_enable,
  input wire logic [video_capture_pkg::MASK_W-1:0] input_mask,
  input wire logic pll_clock,
  input wire logic pll_out_disable,
  input wire logic out_ready,
  output video_capture_pkg::capture_word_t out_word,
  output logic out_valid,
  output logic line_sync_out,
  output logic composite_sync_out,
  output logic system_pll_clock_out,
  output logic system_pll_clock_out_oe_n,
  output logic overflow
);
  import video_capture_pkg::*;

  // Every check below runs on the core clock and pauses during reset.
  default clocking cb_core @(posedge clock);
  endclocking
  default disable iff (!nrst);

  function automatic logic [PIX_W-1:0] mask_pixels(
    input logic [PIX_W-1:0] pix,
    input logic wide,
    input logic mask_on,
    input logic [MASK_W-1:0] mask
  );
    logic [PIX_W-1:0] res;
    res = pix;
    if (!wide) begin
      res[PIX_W-1:HALF_W] = '0; // R3
    end else if (mask_on) begin
      for (int i = 0; i < MASK_W; i++) begin
        if (mask[i]) begin
          res[HALF_W+i*NIB_W +: NIB_W] = '0; // R17
        end
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on load_clock and every video data pin.
  localparam int SYN_W = PIX_W + LEGACY_W + 4;
  logic [SYN_W-1:0] sync1, sync2;
  logic load_clock_prev;
  logic [SYN_W-1:0] next_sync1, next_sync2;
  logic next_load_clock_prev;

  always_comb begin
    next_sync1 = {vram_word_bus, legacy_byte, blank_n, frame_edge_in,
                  line_sync_in, load_clock};
    next_sync2 = sync1;
    next_load_clock_prev = sync2[0];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
      load_clock_prev <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      load_clock_prev <= next_load_clock_prev;
    end
  end

  logic load_clock_rise;
  assign load_clock_rise = sync2[0] & ~load_clock_prev; // R1 R2

  ////////////////////////////////////////////////////////////////////////////
  // Capture stage and equal-depth pipeline.
  capture_word_t sample;
  logic s_sync, s_frame, s_blank;
  always_comb begin
    s_blank = sync2[3];
    s_frame = sync2[2];
    s_sync = sync2[1] ^ sync_invert; // R14
    sample.pixel = mask_pixels(sync2[SYN_W-1 -: PIX_W], bus_width_select,
                               input_mask_enable, input_mask); // R2
    sample.legacy = sync2[4 +: LEGACY_W]; // R4
    sample.active = s_blank; // R5
    // Border only shows in picture time; blanking hides it regardless.
    sample.show_border = !interlace_mode && s_blank && !s_frame; // R6 R7
    sample.field_odd = interlace_mode & s_frame; // R6 R10
    sample.line_sync = s_sync; // R12
  end

  capture_word_t pipe [DEPTH];
  logic [DEPTH-1:0] pvalid;
  capture_word_t next_pipe [DEPTH];
  logic [DEPTH-1:0] next_pvalid;
  logic stall;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_pipe[i] = pipe[i];
    end
    next_pvalid = pvalid;
    if (load_clock_rise && !stall) begin
      next_pipe[0] = sample; // R18
      next_pvalid[0] = 1'b1;
      for (int i = 1; i < DEPTH; i++) begin
        next_pipe[i] = pipe[i-1]; // R18
        next_pvalid[i] = pvalid[i-1];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        pipe[i] <= '0;
      end
      pvalid <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        pipe[i] <= next_pipe[i];
      end
      pvalid <= next_pvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer.
  capture_word_t buf_mem [2];
  logic [1:0] count;
  logic wr_ptr, rd_ptr;
  logic [1:0] next_count;
  logic next_wr_ptr, next_rd_ptr, next_overflow;
  capture_word_t next_mem [2];
  logic push, pop, in_ready;

  assign in_ready = (count != 2'h2);
  assign stall = !in_ready;
  assign push = load_clock_rise && pvalid[DEPTH-1] && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != 2'h0);
  assign out_word = buf_mem[rd_ptr];

  always_comb begin
    next_mem[0] = buf_mem[0];
    next_mem[1] = buf_mem[1];
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_overflow = overflow;
    if (push) begin
      next_mem[wr_ptr] = pipe[DEPTH-1];
      next_wr_ptr = !wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = !rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
    // A load edge while full drops the incoming sample.
    if (load_clock_rise && stall) begin
      next_overflow = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      overflow <= 1'b0;
    end else begin
      buf_mem[0] <= next_mem[0];
      buf_mem[1] <= next_mem[1];
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      overflow <= next_overflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync output with position trim and PLL clock output.
  logic [(1<<HPOS_W)-1:0] hdelay;
  logic [(1<<HPOS_W)-1:0] next_hdelay;
  logic next_line_sync_out, next_composite;

  always_comb begin
    next_hdelay = hdelay;
    next_line_sync_out = line_sync_out;
    next_composite = composite_sync_out;
    if (load_clock_rise && !stall) begin
      next_hdelay = {hdelay[(1<<HPOS_W)-2:0], pipe[DEPTH-1].line_sync};
      if (composite_sync_mode) begin
        next_composite = pipe[DEPTH-1].line_sync; // R12
      end else begin
        next_line_sync_out = hdelay[hsync_position]; // R13 R16
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hdelay <= '0;
      line_sync_out <= 1'b0;
      composite_sync_out <= 1'b0;
    end else begin
      hdelay <= next_hdelay;
      line_sync_out <= next_line_sync_out;
      composite_sync_out <= next_composite;
    end
  end

  assign system_pll_clock_out = pll_clock; // R15
  assign system_pll_clock_out_oe_n = pll_out_disable; // R15

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_take;
    load_clock_rise && !stall;
  endsequence

  a_narrow_upper_zero: assert property ( // R3
    (load_clock_rise && !stall && !bus_width_select) |=>
      pipe[0].pixel[PIX_W-1:HALF_W] == '0)
    else $error("upper pixel half not cleared");
  a_capture_on_edge: assert property ( // R1
    !load_clock_rise |=> $stable(pipe[0]))
    else $error("capture without load edge");
  a_legacy_sampled: assert property ( // R4
    s_take |=> pipe[0].legacy == $past(sync2[4 +: LEGACY_W]))
    else $error("legacy byte not sampled");
  a_blank_active: assert property ( // R5
    s_take |=> pipe[0].active == $past(sync2[3]))
    else $error("blanking sense wrong");
  a_border_blank: assert property ( // R6 R7
    s_take |=> pipe[0].show_border ==
      (!$past(interlace_mode) && $past(sync2[3]) && !$past(sync2[2])))
    else $error("border select wrong");
  a_sync_invert: assert property ( // R14
    s_take |=>
      pipe[0].line_sync == ($past(sync2[1]) ^ $past(sync_invert)))
    else $error("sync polarity wrong");
  a_mask_nibble: assert property ( // R17
    (load_clock_rise && !stall && bus_width_select && input_mask_enable &&
     input_mask[0]) |=> pipe[0].pixel[HALF_W +: NIB_W] == '0)
    else $error("masked nibble not zero");
  a_pipe_shift: assert property ( // R18
    s_take |=> pipe[1] == $past(pipe[0]))
    else $error("pipeline misaligned");
  a_pll_release: assert property ( // R15
    system_pll_clock_out_oe_n == pll_out_disable)
    else $error("pll output enable wrong");
  a_field_select: assert property ( // R10
    s_take |=> pipe[0].field_odd ==
      ($past(interlace_mode) && $past(sync2[2])))
    else $error("field select wrong");
  a_stall_drops_sample: assert property ( // R18
    (load_clock_rise && stall) |=> $stable(pipe[0]) && overflow)
    else $error("stalled sample not dropped");
  a_overflow_sticky: assert property ( // R18
    overflow |=> overflow)
    else $error("overflow flag cleared");
endmodule

// >>> testbench/video_far_end.sv
// Purpose: Graphics controller model driving load clock and video pins.
// Assumes: Load clock period 125 ns, running only while run is high.
// Notes: Pins change on the falling load edge, away from the capture edge.
`timescale 1ns/1ps

module video_far_end
  import video_capture_pkg::*;
(
  input wire logic run,
  input wire logic interlace,
  input wire logic field,
  output logic load_clock,
  output logic [video_capture_pkg::PIX_W-1:0] vram_word_bus,
  output logic [video_capture_pkg::LEGACY_W-1:0] legacy_byte,
  output logic blank_n,
  output logic frame_edge_in,
  output logic line_sync_in
);
  capture_word_t cur;
  int idx;

  function automatic capture_word_t pat(input int n);
    capture_word_t p;
    logic [7:0] b;
    b = n[7:0];
    p.pixel = {24'hA5C3E1, b, 24'h5A3C1E, b};
    p.legacy = b ^ 8'h3C;
    p.active = b[2] | b[0];
    p.show_border = interlace ? field : p.active & b[1];
    p.field_odd = p.show_border;
    p.line_sync = b[1] ^ b[3];
    return p;
  endfunction

  assign vram_word_bus = cur.pixel;
  assign legacy_byte = cur.legacy;
  assign blank_n = cur.active;
  assign frame_edge_in = cur.show_border;
  assign line_sync_in = cur.line_sync;

  initial begin
    load_clock = 1'h0;
    cur = pat(0);
    forever begin
      @(posedge run);
      idx = 1;
      cur = pat(idx);
      #1.3;
      while (run) begin
        #62.5 load_clock = 1'h1;
        #62.5 load_clock = 1'h0;
        idx++;
        cur = pat(idx);
      end
    end
  end
endmodule

// >>> testbench/video_input_capture_tb_top.sv
// Purpose: Self-checking bench for the video input capture block.
// Assumes: Far-end model supplies load clock and video pins.
// Notes: Sync outputs are checked at each falling load clock edge.
`timescale 1ns/1ps

module video_input_capture_tb_top;
  import video_capture_pkg::*;
  localparam int DEPTH = PIPE_DEPTH;
  int edges_seen = 0;
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic load_clock, blank_n, frame_edge_in, line_sync_in;
  logic [PIX_W-1:0] vram_word_bus;
  logic [LEGACY_W-1:0] legacy_byte;
  logic bus_width_select = 1'h1, interlace_mode = 1'h0;
  logic composite_sync_mode = 1'h0, sync_invert = 1'h0;
  logic [HPOS_W-1:0] hsync_position = 3'h0;
  logic input_mask_enable = 1'h0, pll_clock = 1'h0;
  logic [MASK_W-1:0] input_mask = 8'h0;
  logic pll_out_disable = 1'h0, out_ready = 1'h0;
  capture_word_t out_word;
  logic out_valid, line_sync_out, composite_sync_out, overflow;
  logic system_pll_clock_out, system_pll_clock_out_oe_n;
  logic run = 1'h0, field = 1'h0, stall = 1'h0, last_ls = 1'h0;
  int num_errors = 0, num_checks = 0, cycles = 0, next_idx = 1, moves = 0;
  logic [7:0] cfgs [4] = '{8'h01, 8'h3E, 8'hCB, 8'h67};
  logic [7:0] masks [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};

  video_input_capture dut (.clock(clock), .nrst(nrst),
    .load_clock(load_clock), .vram_word_bus(vram_word_bus),
    .legacy_byte(legacy_byte), .blank_n(blank_n),
    .frame_edge_in(frame_edge_in), .line_sync_in(line_sync_in),
    .bus_width_select(bus_width_select), .interlace_mode(interlace_mode),
    .composite_sync_mode(composite_sync_mode), .sync_invert(sync_invert),
    .hsync_position(hsync_position), .input_mask_enable(input_mask_enable),
    .input_mask(input_mask), .pll_clock(pll_clock),
    .pll_out_disable(pll_out_disable), .out_ready(out_ready),
    .out_word(out_word), .out_valid(out_valid),
    .line_sync_out(line_sync_out), .composite_sync_out(composite_sync_out),
    .system_pll_clock_out(system_pll_clock_out),
    .system_pll_clock_out_oe_n(system_pll_clock_out_oe_n),
    .overflow(overflow));
  video_far_end u_far (.run(run), .interlace(interlace_mode),
    .field(field), .load_clock(load_clock), .vram_word_bus(vram_word_bus),
    .legacy_byte(legacy_byte), .blank_n(blank_n),
    .frame_edge_in(frame_edge_in), .line_sync_in(line_sync_in));

  always #2.5 clock = ~clock;

  task automatic test_done();
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic capture_word_t expect_word(capture_word_t r);
    capture_word_t e;
    e = r;
    if (!bus_width_select) e.pixel[PIX_W-1:HALF_W] = 32'h0;
    else if (input_mask_enable)
      for (int i = 0; i < MASK_W; i++)
        if (input_mask[i]) e.pixel[HALF_W+NIB_W*i +: NIB_W] = 4'h0;
    e.show_border = !interlace_mode & r.active & !r.show_border;
    e.field_odd = interlace_mode & r.field_odd;
    e.line_sync = r.line_sync ^ sync_invert;
    return e;
  endfunction

  function automatic logic exp_sync(input int k);
    capture_word_t w;
    w = u_far.pat(k);
    return w.line_sync ^ sync_invert;
  endfunction

  always @(posedge load_clock) edges_seen++;

  // Sample k sits DEPTH edges in the pipe, then hsync_position+1 more.
  always @(negedge load_clock) begin
    int n;
    n = edges_seen - DEPTH;
    if (!stall && composite_sync_mode && n >= 1)
      chk(WORD_W'(composite_sync_out), WORD_W'(exp_sync(n)));
    n = n - 1 - int'(hsync_position);
    if (!stall && !composite_sync_mode && n >= 1)
      chk(WORD_W'(line_sync_out), WORD_W'(exp_sync(n)));
  end

  always @(posedge clock) begin
    capture_word_t g;
    cycles <= cycles + 1;
    pll_clock <= ~pll_clock;
    out_ready <= ~stall & ~cycles[1];
    last_ls <= line_sync_out;
    if (line_sync_out !== last_ls) moves++;
    if (out_valid === 1'h1 && out_ready === 1'h1) begin
      g = out_word;
      chk(g, expect_word(u_far.pat(next_idx)));
      next_idx++;
    end
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic do_run(input logic [7:0] c, input logic [7:0] m,
      input int edges);
    @(posedge clock);
    nrst <= 1'h0;
    bus_width_select <= c[0];
    input_mask_enable <= c[1];
    sync_invert <= c[2];
    interlace_mode <= c[3];
    field = c[4];
    composite_sync_mode <= c[5];
    hsync_position <= c[7:5];
    input_mask <= m;
    repeat (12) @(posedge clock);
    nrst <= 1'h1;
    next_idx = 1;
    edges_seen = 0;
    @(posedge clock);
    chk(WORD_W'(overflow), WORD_W'(0));
    run = 1'h1;
    repeat (edges) @(posedge load_clock);
    run = 1'h0;
    repeat (60) @(posedge clock);
  endtask

  initial begin
    for (int k = 0; k < 4; k++) begin
      do_run(cfgs[k], masks[k], 14);
      chk(WORD_W'(next_idx), WORD_W'(15 - DEPTH));
    end
    chk(WORD_W'(moves > 0), WORD_W'(1));
    for (int d = 0; d < 2; d++) begin
      @(posedge clock);
      pll_out_disable <= d[0];
      @(negedge clock);
      chk(WORD_W'(system_pll_clock_out_oe_n), WORD_W'(d[0]));
      if (d == 0) chk(WORD_W'(system_pll_clock_out), WORD_W'(pll_clock));
    end
    stall = 1'h1;
    do_run(8'h01, 8'h00, 12);
    chk(WORD_W'({overflow, out_valid}), WORD_W'(3));
    test_done();
  end
endmodule
